// File: rtl/cpu_supervisor_watchdog.sv
// cpu_supervisor_watchdog: supply, pushbutton and watchdog reset supervisor.
// assumes all inputs synchronous to clock; supply comparators arrive as digital flags.
//
// Operation
// - hold reset until supply good 610ms continuously
// - tolerance select picks 5% or 10% threshold
// - power-up reset lasts 250 to 1000 ms
// - manual reset pulses under 1ms are ignored
// - manual reset low 20ms always resets
// - reset after manual low for pushbutton delay
// - reset held 610ms after manual release
// - only falling strobe edges service watchdog
// - missed strobe forces reset pulse
// - reset pulses repeat until strobe arrives
// - period select gives 150, 600, 1200 ms
// - complementary outputs, active-low leg open drain
`timescale 1ns/10ps
module cpu_supervisor_watchdog #(
    parameter int unsigned TICK_CYCLES = supervisor_pkg::TICK_CYCLES
) (
    input  wire logic                         clock,
    input  wire logic                         reset,
    input  wire logic                         supply_above_5pct,
    input  wire logic                         supply_above_10pct,
    input  wire logic                         supply_tolerance_select,
    input  wire logic                         manual_reset_n,
    input  wire logic                         watchdog_strobe,
    input  wire logic [1:0]                   watchdog_period_select,
    output supervisor_pkg::reset_pair_t       reset_out
);

    localparam logic [supervisor_pkg::TICK_CNT_W-1:0] TICK_LAST =
        supervisor_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

    logic [supervisor_pkg::TICK_CNT_W-1:0] tick_cnt_q;
    logic                                  tick_q;
    logic                                  strobe_prev_q;
    logic                                  reset_q;
    logic                                  supply_ok;
    logic                                  strobe_fall;
    logic                                  pb_done;
    logic                                  pb_hit;
    logic                                  wd_done;
    logic                                  stretch_done;
    logic                                  cause;
    logic [supervisor_pkg::MS_W-1:0]       wd_limit;
    logic [supervisor_pkg::MS_W-1:0]       pb_elapsed;
    logic [supervisor_pkg::MS_W-1:0]       wd_elapsed;
    logic [supervisor_pkg::MS_W-1:0]       stretch_elapsed;

    // ****************************************************************
    // timebase
    // ****************************************************************
    // one shared millisecond tick; every duration below counts these
    always_ff @(posedge clock) begin
        if (reset || (tick_cnt_q == TICK_LAST)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_LAST);
        end
    end

    // ****************************************************************
    // supply qualification
    // ****************************************************************
    // comparator choice follows the strapped tolerance
    always_comb begin
        if (supervisor_pkg::tolerance_t'(supply_tolerance_select) ==
            supervisor_pkg::TOL_10PCT) begin
            supply_ok = supply_above_10pct;
        end else begin
            supply_ok = supply_above_5pct;
        end
    end

    // ****************************************************************
    // manual reset debounce
    // ****************************************************************
    // low must persist for the pushbutton delay; any high restarts it,
    // so bounces and sub-millisecond glitches never reach the reset
    ms_interval_timer #(
        .WIDTH (supervisor_pkg::MS_W)
    ) u_pushbutton_delay (
        .clock   (clock),
        .reset   (reset),
        .clear   (manual_reset_n),
        .tick    (tick_q),
        .limit   (supervisor_pkg::PUSHBUTTON_DELAY_MS),
        .elapsed (pb_elapsed),
        .done    (pb_done)
    );

    assign pb_hit = pb_done && !manual_reset_n;

    // ****************************************************************
    // watchdog
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= watchdog_strobe;
        end
    end

    // only high-to-low is service; rising edges and levels do nothing
    assign strobe_fall = strobe_prev_q && !watchdog_strobe;

    // an illegal pad code is treated as the floating setting
    always_comb begin
        unique case (supervisor_pkg::period_select_t'(watchdog_period_select))
            supervisor_pkg::PERIOD_LOW:   wd_limit = supervisor_pkg::WD_SHORT_MS;
            supervisor_pkg::PERIOD_FLOAT: wd_limit = supervisor_pkg::WD_MID_MS;
            supervisor_pkg::PERIOD_HIGH:  wd_limit = supervisor_pkg::WD_LONG_MS;
            default:                      wd_limit = supervisor_pkg::WD_MID_MS;
        endcase
    end

    // held clear for the whole reset, so it restarts from zero at release
    ms_interval_timer #(
        .WIDTH (supervisor_pkg::MS_W)
    ) u_watchdog_timeout (
        .clock   (clock),
        .reset   (reset),
        .clear   (reset_q || strobe_fall),
        .tick    (tick_q),
        .limit   (wd_limit),
        .elapsed (wd_elapsed),
        .done    (wd_done)
    );

    // ****************************************************************
    // reset stretcher
    // ****************************************************************
    assign cause = !supply_ok || pb_hit || wd_done;

    // counts only while no cause is present, so any dip restarts the wait
    ms_interval_timer #(
        .WIDTH (supervisor_pkg::MS_W)
    ) u_reset_stretch (
        .clock   (clock),
        .reset   (reset),
        .clear   (cause),
        .tick    (tick_q),
        .limit   (supervisor_pkg::RESET_ACTIVE_MS),
        .elapsed (stretch_elapsed),
        .done    (stretch_done)
    );

    // power-on starts asserted; cause wins over release in the same cycle
    always_ff @(posedge clock) begin
        if (reset || cause) begin
            reset_q <= 1'b1;
        end else if (stretch_done) begin
            reset_q <= 1'b0;
        end
    end

    // ****************************************************************
    // output pair
    // ****************************************************************
    // open-drain leg only ever pulls low; an outside pull-up gives high
    assign reset_out.active_high   = reset_q;
    assign reset_out.active_low_o  = 1'b0;
    assign reset_out.active_low_oe = reset_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_release;
        $fell(reset_q);
    endsequence

    sequence s_wd_expiry;
        wd_done && supply_ok && manual_reset_n;
    endsequence

    a_supply_low_reset: assert property (!supply_ok |=> reset_q)
        else $error("reset not held while supply low");

    a_tol_five_pct: assert property (
        (!supply_tolerance_select && !supply_above_5pct) |=> reset_q)
        else $error("5 pct threshold not applied");

    a_tol_ten_pct: assert property (
        (supply_tolerance_select && supply_above_10pct && !supply_above_5pct
         && !reset_q && !wd_done && manual_reset_n) |=> !reset_q)
        else $error("10 pct threshold not applied");

    a_release_full_wait: assert property (
        s_release |-> $past(stretch_elapsed) == supervisor_pkg::RESET_ACTIVE_MS)
        else $error("reset released before active time");

    a_reset_has_cause: assert property (
        $rose(reset_q) |-> $past(!supply_ok || pb_hit || wd_done))
        else $error("reset asserted without cause");

    a_pb_delay_hit: assert property (
        (!manual_reset_n && pb_elapsed == supervisor_pkg::PUSHBUTTON_DELAY_MS)
        |=> reset_q)
        else $error("pushbutton delay did not reset");

    a_pb_release_hold: assert property (
        ($rose(manual_reset_n) && reset_q) |-> reset_q [*8])
        else $error("reset dropped right after release");

    a_rise_ignored: assert property (
        ($rose(watchdog_strobe) && !reset_q && !tick_q && !cause)
        |=> wd_elapsed == $past(wd_elapsed))
        else $error("rising strobe serviced watchdog");

    a_wd_fires: assert property (s_wd_expiry |=> reset_q)
        else $error("watchdog expiry did not reset");

    a_wd_restart: assert property (s_release |-> wd_elapsed == '0)
        else $error("watchdog not restarted after pulse");

    a_wd_period: assert property (
        ($rose(reset_q) && $past(supply_ok && !pb_hit))
        |-> $past(wd_elapsed) == $past(wd_limit))
        else $error("watchdog expired at wrong period");

    a_pair_match: assert property (
        reset_out.active_high == reset_out.active_low_oe && !reset_out.active_low_o)
        else $error("reset pair disagrees");

    a_wd_idle_reset: assert property (reset_q |=> wd_elapsed == '0)
        else $error("watchdog counted during reset");

    a_tick_single: assert property (tick_q |=> !tick_q)
        else $error("tick wider than one cycle");

endmodule : cpu_supervisor_watchdog

// File: rtl/ms_interval_timer.sv
// ms_interval_timer: saturating counter of timebase ticks with a terminal flag.
// assumes tick is a one-cycle pulse and clear may be held for many cycles.
`timescale 1ns/10ps
module ms_interval_timer #(
    parameter int unsigned WIDTH = supervisor_pkg::MS_W
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] limit,
    output logic      [WIDTH-1:0] elapsed,
    output logic                  done
);

    logic [WIDTH-1:0] count_q;

    // ****************************************************************
    // counting
    // ****************************************************************
    // saturate at the limit so a held condition never wraps back to idle
    always_ff @(posedge clock) begin
        if (reset || clear) begin
            count_q <= '0;
        end else if (tick && (count_q < limit)) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign elapsed = count_q;
    assign done    = (count_q >= limit);

endmodule : ms_interval_timer

// File: rtl/supervisor_pkg.sv
// supervisor_pkg: constants, enumerations and carriers for the cpu supervisor.
// assumes a single 50 MHz clock and a 1 ms internal timebase derived from it.
package supervisor_pkg;

    // ****************************************************************
    // clock and timebase
    // ****************************************************************
    localparam int unsigned CLOCK_PERIOD_NS = 20;
    localparam int unsigned TICK_PERIOD_NS  = 1_000_000;       // one millisecond
    // cycles per tick, rounded down; 50,000 at the documented clock
    localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int unsigned TICK_CNT_W      = 16;

    // ****************************************************************
    // millisecond durations, counted in timebase ticks
    // ****************************************************************
    localparam int unsigned MS_W = 11;
    localparam logic [MS_W-1:0] RESET_ACTIVE_MS     = 11'h262;   // 610 ms typical
    localparam logic [MS_W-1:0] PUSHBUTTON_DELAY_MS = 11'h004;   // 4 ms typical
    localparam logic [MS_W-1:0] WD_SHORT_MS         = 11'h096;   // 150 ms
    localparam logic [MS_W-1:0] WD_MID_MS           = 11'h258;   // 600 ms
    localparam logic [MS_W-1:0] WD_LONG_MS          = 11'h4b0;   // 1200 ms

    // ****************************************************************
    // select encodings
    // ****************************************************************
    typedef enum logic {
        TOL_5PCT  = 1'b0,
        TOL_10PCT = 1'b1
    } tolerance_t;

    // three-state period pin, resolved to two bits by the pad
    typedef enum logic [1:0] {
        PERIOD_LOW   = 2'b00,
        PERIOD_FLOAT = 2'b01,
        PERIOD_HIGH  = 2'b10,
        PERIOD_BAD   = 2'b11
    } period_select_t;

    // complementary reset pair; the active-low leg is open drain
    typedef struct packed {
        logic active_high;
        logic active_low_o;
        logic active_low_oe;
    } reset_pair_t;

endpackage : supervisor_pkg

// File: tb/cpu_model.sv
// cpu_model: supervised processor that strobes the watchdog and takes reset.
// assumes rst_n is the resolved open-drain reset wire with its pull-up.
`timescale 1ns/10ps
module cpu_model (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        stop,
    input  wire logic [15:0] half_period,
    output logic             watchdog_strobe
);
    logic [15:0] count_q;
    // toggle the i/o line after the edge by the bench's own input delay;
    // the reset branch also gives the power-on level, so one process drives it
    always @(posedge clock) begin
        #2;
        if (rst_n !== 1'b1) begin
            watchdog_strobe <= 1'b1; // a core in reset runs no code
            count_q         <= '0;
        end else if (count_q + 16'h0001 >= half_period) begin
            count_q <= '0;
            // stopped: a low line makes one last rise, a high line stays; then a static high level
            if (!stop || !watchdog_strobe) watchdog_strobe <= ~watchdog_strobe;
        end else begin
            count_q <= count_q + 16'h0001;
        end
    end
endmodule : cpu_model

// File: tb/tb.sv
// tb: self-checking bench for the cpu supervisor and a processor model.
// assumes a 20 ns clock; TICK_CYCLES cut to 4 so every duration stays short.
`timescale 1ns/10ps
module tb;
    localparam int T = 4;
    logic                        clock;
    logic                        reset;
    logic                        above_5;
    logic                        above_10;
    logic                        tol_sel;
    logic                        manual_reset_n;
    logic                        stop;
    logic [15:0]                 half_period;
    logic [1:0]                  period_sel;
    logic                        watchdog_strobe;
    logic                        rst_n_wire;
    int                          cyc;
    int                          fall_cyc;
    int                          num_errors;
    int                          comparisons;
    int                          n;
    int                          p;
    int                          r;
    supervisor_pkg::reset_pair_t reset_out;

    // open-drain leg with its external pull-up
    assign rst_n_wire = reset_out.active_low_oe ? reset_out.active_low_o : 1'b1;

    cpu_supervisor_watchdog #(.TICK_CYCLES(T)) cpu_supervisor_watchdog_inst (
        .clock                   (clock),
        .reset                   (reset),
        .supply_above_5pct       (above_5),
        .supply_above_10pct      (above_10),
        .supply_tolerance_select (tol_sel),
        .manual_reset_n          (manual_reset_n),
        .watchdog_strobe         (watchdog_strobe),
        .watchdog_period_select  (period_sel),
        .reset_out               (reset_out)
    );
    cpu_model cpu_model_inst (
        .clock           (clock),
        .rst_n           (rst_n_wire),
        .stop            (stop),
        .half_period     (half_period),
        .watchdog_strobe (watchdog_strobe)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // cycle count and hang guard
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 100000) begin
            num_errors = num_errors + 1;
            complete_run();
        end
    end
    always @(negedge watchdog_strobe) fall_cyc = cyc;

    function automatic int period_ticks(input logic [1:0] s);
        case (s)
            2'b00:   return int'(supervisor_pkg::WD_SHORT_MS);
            2'b10:   return int'(supervisor_pkg::WD_LONG_MS);
            default: return int'(supervisor_pkg::WD_MID_MS); // open and bad code
        endcase
    endfunction : period_ticks
    function automatic logic in_range(input int k, input int lo, input int hi);
        return (k >= lo) && (k <= hi);
    endfunction : in_range
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask : step
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_for(input logic v, input int lim, output int k);
        k = 0;
        while (reset_out.active_high !== v && k < lim) begin
            step(1);
            k = k + 1;
        end
    endtask : wait_for
    task automatic check_pair(input logic v);
        check({reset_out.active_high, reset_out.active_low_oe}, {v, v});
        check({reset_out.active_low_o, rst_n_wire}, {1'b0, ~v});
    endtask : check_pair
    // release follows the stretch: 610 ticks counted, the first may be partial
    task automatic exp_release();
        wait_for(1'b0, (r + 1) * T + 10, n);
        check(in_range(n, (r - 1) * T + 2, r * T + 2), 1'b1);
        check_pair(1'b0);
    endtask : exp_release
    task automatic complete_run();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        {reset, above_5, above_10, manual_reset_n} = 4'b1111;
        {tol_sel, stop, period_sel} = 4'b0000;
        half_period = 16'h0032;
        {cyc, fall_cyc, num_errors, comparisons} = {4{32'sd0}};
        r = int'(supervisor_pkg::RESET_ACTIVE_MS);
        n = $urandom(81048);
        step(10);
        reset = 1'b0;
        check_pair(1'b1);
        exp_release();
        $display("test power_up done");
        // 10% threshold chosen: a dip below only the 5% level is ignored
        tol_sel = 1'b1;
        above_5 = 1'b0;
        wait_for(1'b1, 50, n);
        check(n, 50);
        above_10 = 1'b0;
        wait_for(1'b1, 3, n);
        check(n < 3, 1'b1);
        // 5% chosen: the low 5% flag alone keeps reset, a good 10% flag is ignored
        tol_sel  = 1'b0;
        above_10 = 1'b1;
        step(100);
        above_5 = 1'b1;
        exp_release();
        // one-cycle dips: one from idle, one mid-stretch that restarts it
        tol_sel = 1'($urandom_range(1, 0));
        for (int d = 0; d < 2; d++) begin
            above_5  = 1'b0;
            above_10 = !tol_sel;
            step(1);
            {above_5, above_10} = 2'b11;
            check(reset_out.active_high, 1'b1);
            if (d == 0) step(300 * T);
        end
        exp_release();
        $display("test supply done");
        for (int i = 0; i < 3; i++) begin
            manual_reset_n = 1'b0;
            step($urandom_range(3 * T - 1, 1));
            manual_reset_n = 1'b1;
            wait_for(1'b1, 6 * T, n);
            check(n, 6 * T);
        end
        manual_reset_n = 1'b0;
        wait_for(1'b1, 21 * T, n);
        check(in_range(n, 3 * T, 5 * T + 2), 1'b1);
        step(20 * T - n);
        manual_reset_n = 1'b1;
        exp_release();
        $display("test manual done");
        for (int s = 0; s < 4; s++) begin
            period_sel  = 2'(s);
            p           = period_ticks(period_sel) * T;
            half_period = 16'($urandom_range(140, 10));
            wait_for(1'b1, 2 * p, n);
            check(n, 2 * p);
            stop = 1'b1; // last fall, a rise only if still low, then static high
            wait_for(1'b1, 2 * p, n);
            check(in_range(cyc - fall_cyc, p - T, p + T + 3), 1'b1);
            exp_release();
            wait_for(1'b1, 2 * p, n);
            check(in_range(n, p - T, p + T + 3), 1'b1);
            stop = 1'b0;
            exp_release();
            $display("test watchdog code %0d done", s);
        end
        wait_for(1'b1, 2 * p, n);
        check(n, 2 * p);
        complete_run();
    end
endmodule : tb
